// ===== common/pofl_pkg.sv
// Constants for the protected output fault logic
// Behaviour
// - One byte per update, bit per point
// - Shifted stream looped back during transfer
// - Serial data converted to parallel drive
// - Each point watches overcurrent and short
// - First trip: off then on within 1.5ms
// - Trip persisting after retry latches fault
// - Latched fault forces point off
// - On commands ignored while fault latched
// - Clear command, table clear or power cycle
// - Overcurrent trip near 2.5A, separate detector
// - Fault lights on/off and fault indicators
// - Per-point on/off indicator shows switched state or latched fault
// - Per-point fault indicator shows fault status
// - On/off indicators dark without field power
// - Power indicator needs field and logic power
package pofl_pkg;
  localparam int POINTS = 8;
  localparam int CLK_MHZ = 50;
  // Retry off time and retry on-phase window after turn-on, microseconds
  localparam int RETRY_OFF_US = 500;
  localparam int RETRY_MAX_US = 1500;
  localparam int RETRY_OFF_CYC = RETRY_OFF_US * CLK_MHZ;
  localparam int RETRY_MAX_CYC = RETRY_MAX_US * CLK_MHZ;
  localparam int TIMER_W = 17;
  // Wishbone register byte addresses
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_IDENT = 4'hc;
  // Control bits
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_TABLE_BIT = 1;
  // Identity, arbitrary value
  localparam logic [7:0] IDENT_VALUE = 8'h5a;
  typedef enum logic [3:0] {
    PT_IDLE = 4'h1,
    PT_OFF = 4'h2,
    PT_ON = 4'h4,
    PT_FAULT = 4'h8
  } pofl_pt_t;
endpackage

// ===== dv/pofl_host_link.sv
// Host link model shifting output bytes in
`timescale 1ns/1ps
module pofl_host_link (
  input wire logic clock,
  output logic serClk = 1'b0,
  output logic serData = 1'b0,
  output logic serLatch = 1'b0
);
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock) serData <= b[i];
      repeat (2) @(posedge clock);
      @(posedge clock) serClk <= 1'b1;
      repeat (4) @(posedge clock);
      @(posedge clock) serClk <= 1'b0;
    end
    // Released line shows inverse, clock parked low
    @(posedge clock) serData <= ~b[0];
    serLatch <= 1'b1;
    repeat (3) @(posedge clock);
    @(posedge clock) serLatch <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
endmodule

// ===== dv/pofl_monitor.sv
// Port checker for the output fault logic
`timescale 1ns/1ps
module pofl_monitor
  import pofl_pkg::*;
#(
  parameter int N = POINTS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serReturn,
  input wire logic fieldPower,
  input wire logic logicPower,
  input wire logic [N-1:0] pointDrive,
  input wire logic [N-1:0] onOffLed,
  input wire logic [N-1:0] faultLed,
  input wire logic powerOkLed
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_loop;
    $rose(serClk) && $stable(serData) |-> ##[1:4] serReturn == serData;
  endproperty
  a_loop: assert property (p_loop) else $error("no loopback");
  property p_off;
    (faultLed & $past(faultLed, 2) & pointDrive) == '0;
  endproperty
  a_off: assert property (p_off) else $error("faulted point on");
  property p_dark;
    !fieldPower [*4] |-> onOffLed == '0;
  endproperty
  a_dark: assert property (p_dark) else $error("led lit unpowered");
  property p_pwr;
    $stable(fieldPower && logicPower) [*4] |->
      powerOkLed == (fieldPower && logicPower);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power led");
  property p_both;
    fieldPower [*4] |-> (faultLed & $past(faultLed) & ~onOffLed) == '0;
  endproperty
  a_both: assert property (p_both) else $error("fault leds");
  property p_id;
    wb_ack_o && $past(wb_adr_i) == ADDR_IDENT && !$past(wb_we_i) |->
      wb_dat_o[7:0] == IDENT_VALUE;
  endproperty
  a_id: assert property (p_id) else $error("identity");
  property p_stat;
    wb_ack_o && $past(wb_adr_i) == ADDR_STATUS && $stable(faultLed) |->
      wb_dat_o[7:0] == faultLed;
  endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
endmodule
bind pofl_top pofl_monitor #(.N(N)) mon (
  .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serClk(serClk), .serData(serData), .serReturn(serReturn),
  .fieldPower(fieldPower), .logicPower(logicPower), .pointDrive(pointDrive),
  .onOffLed(onOffLed), .faultLed(faultLed), .powerOkLed(powerOkLed));

// ===== dv/pofl_top_tb.sv
// Bench for the protected output fault logic
`timescale 1ns/1ps
module pofl_top_tb;
  import pofl_pkg::*;
  logic clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serReturn;
  logic serClk, serData, serLatch, fieldPower, logicPower, powerOkLed;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [7:0] overCurrent, shortCircuit, pointDrive, onOffLed, faultLed;
  int fails = 0, checks = 0, cyc = 0;
  pofl_top dut (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serClk(serClk), .serData(serData),
    .serLatch(serLatch), .serReturn(serReturn), .overCurrent(overCurrent),
    .shortCircuit(shortCircuit), .fieldPower(fieldPower), .logicPower(logicPower),
    .pointDrive(pointDrive), .onOffLed(onOffLed), .faultLed(faultLed),
    .powerOkLed(powerOkLed));
  pofl_host_link link (.clock, .serClk, .serData, .serLatch);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic close_out();
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  // Ceiling sits just above the three overlapping retry runs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {overCurrent, shortCircuit} = '0;
    {fieldPower, logicPower, wb_sel_i} = 6'h3f;
    w(12);
    rstn <= 1'b1;
    wb(1'b0, ADDR_IDENT, 32'h0);
    chk(q[7:0], IDENT_VALUE);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h300);
    link.send(8'ha5);
    w(4);
    chk(serReturn, 1'b1);
    chk(pointDrive, 8'ha5);
    chk(onOffLed, 8'ha5);
    wb(1'b0, ADDR_DATA, 32'h0);
    chk(q, 32'ha5);
    // Staggered trips, so each clear path meets its own latched fault
    overCurrent[0] <= 1'b1;
    shortCircuit[2] <= 1'b1;
    w(40);
    chk(pointDrive, 8'ha0);
    w(26000);
    chk(pointDrive, 8'ha5);
    overCurrent[5] <= 1'b1;
    w(14000);
    overCurrent[7] <= 1'b1;
    w(12000);
    chk(pointDrive, 8'h20);
    chk(faultLed, 8'h05);
    chk(onOffLed, 8'h25);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h305);
    overCurrent[0] <= 1'b0;
    shortCircuit[2] <= 1'b0;
    link.send(8'hff);
    w(4);
    chk(pointDrive, 8'h7a);
    wb(1'b1, ADDR_CONTROL, 32'h2);
    w(4);
    chk(pointDrive, 8'h7f);
    chk(faultLed, 8'h00);
    fieldPower <= 1'b0;
    w(6);
    chk(onOffLed, 8'h00);
    chk(powerOkLed, 1'b0);
    fieldPower <= 1'b1;
    w(24000);
    chk(faultLed, 8'h20);
    chk(pointDrive, 8'hdf);
    chk(onOffLed, 8'hff);
    overCurrent[5] <= 1'b0;
    wb(1'b1, ADDR_CONTROL, 32'h1);
    w(4);
    chk(pointDrive, 8'hff);
    w(14000);
    chk(faultLed, 8'h80);
    chk(pointDrive, 8'h7f);
    overCurrent[7] <= 1'b0;
    fieldPower <= 1'b0;
    w(6);
    fieldPower <= 1'b1;
    w(6);
    chk(faultLed, 8'h00);
    chk(pointDrive, 8'hff);
    close_out();
  end
endmodule

// ===== logic/pofl_point.sv
// Per-point retry and fault latch
`timescale 1ns/1ps
module pofl_point
  import pofl_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic command,
  input wire logic trip,
  input wire logic clear,
  output logic drive,
  output logic fault
);
  pofl_pt_t state;
  pofl_pt_t next_state;
  logic [TIMER_W-1:0] timer;
  wire offDone = timer >= TIMER_W'(RETRY_OFF_CYC - 1);
  wire winDone = timer >= TIMER_W'(RETRY_MAX_CYC - 1);
  ////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      PT_IDLE: if (trip && command) next_state = PT_OFF;
      PT_OFF: if (offDone) next_state = PT_ON;
      PT_ON: begin
        if (trip && offDone) next_state = PT_FAULT;
        else if (winDone) next_state = PT_IDLE;
      end
      PT_FAULT: if (clear) next_state = PT_IDLE;
      default: next_state = PT_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= PT_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= (next_state != state) ? '0 : timer + 1'b1;
    end
  end
  // Fault and retry force off; on ignored
  assign drive = command && (state == PT_IDLE || state == PT_ON);
  assign fault = (state == PT_FAULT);
endmodule

// ===== logic/pofl_sync.sv
// Two-flop synchroniser, vector wide
`timescale 1ns/1ps
module pofl_sync #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage <= '0;
      dout <= '0;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule

// ===== logic/pofl_top.sv
// Protected eight-point output logic with serial link and Wishbone
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module pofl_top
  import pofl_pkg::*;
#(
  parameter int N = POINTS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLatch,
  output logic serReturn,
  input wire logic [N-1:0] overCurrent,
  input wire logic [N-1:0] shortCircuit,
  input wire logic fieldPower,
  input wire logic logicPower,
  output logic [N-1:0] pointDrive,
  output logic [N-1:0] onOffLed,
  output logic [N-1:0] faultLed,
  output logic powerOkLed
);
  ////////////////////////////////////////////////////////////
  logic [N-1:0] shiftReg;
  logic [N-1:0] command;
  logic serClkPrev;
  logic latchPrev;
  logic fieldPrev;
  logic [N-1:0] ocSync;
  logic [N-1:0] scSync;
  logic [N-1:0] drive;
  logic [N-1:0] fault;
  logic clearPulse;
  wire serRise = serClk && !serClkPrev;
  wire latchRise = serLatch && !latchPrev;
  wire [N-1:0] trip = ocSync | scSync;
  wire powerBack = fieldPower && !fieldPrev;
  wire clearAll = clearPulse || powerBack;
  pofl_sync #(.W(N)) syncOc (
    .clock(clock), .rstn(rstn), .din(overCurrent), .dout(ocSync));
  pofl_sync #(.W(N)) syncSc (
    .clock(clock), .rstn(rstn), .din(shortCircuit), .dout(scSync));
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gPt
      pofl_point pt (
        .clock(clock), .rstn(rstn), .command(command[g]), .trip(trip[g]),
        .clear(clearAll), .drive(drive[g]), .fault(fault[g]));
    end
  endgenerate
  ////////////////////////////////////////////////////////////
  // Serial link, sampled on the system clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serClkPrev <= 1'b0;
      latchPrev <= 1'b0;
      fieldPrev <= 1'b0;
      shiftReg <= '0;
      command <= '0;
      serReturn <= 1'b0;
    end else begin
      serClkPrev <= serClk;
      latchPrev <= serLatch;
      fieldPrev <= fieldPower;
      if (serRise) begin
        shiftReg <= {shiftReg[N-2:0], serData};
        serReturn <= serData;
      end
      if (latchRise) begin
        command <= shiftReg;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wrCtrl = acc && wb_we_i && wb_adr_i == ADDR_CONTROL && wb_sel_i[0];
  wire [31:0] rdMux =
    (wb_adr_i == ADDR_DATA) ? {24'h0, command} :
    (wb_adr_i == ADDR_STATUS) ? {22'h0, logicPower, fieldPower, fault} :
    (wb_adr_i == ADDR_IDENT) ? {24'h0, IDENT_VALUE} : 32'h0;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      clearPulse <= 1'b0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rdMux : 32'h0;
      clearPulse <= wrCtrl && (wb_dat_i[CTRL_CLEAR_BIT] || wb_dat_i[CTRL_TABLE_BIT]);
    end
  end
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pointDrive <= '0;
      onOffLed <= '0;
      faultLed <= '0;
      powerOkLed <= 1'b0;
    end else begin
      pointDrive <= drive;
      onOffLed <= fieldPower ? (drive | fault) : '0;
      faultLed <= fault;
      powerOkLed <= fieldPower && logicPower;
    end
  end
endmodule
